// File: can_msg_cfg.svh
// Constants for the message object handler
`ifndef CAN_MSG_CFG_SVH
`define CAN_MSG_CFG_SVH
`define MO_COUNT 32
`define MO_FIFO_DEPTH 16
`define MO_STD_ID_MASK 29'h1FFC0000
`define MO_ALL_ID_MASK 29'h1FFFFFFF
`define MO_MAX_BYTES 4'h8
`define MO_IRQ_NONE 16'h0000
`define MO_IRQ_STATUS 16'h8000
`endif

// File: can_msg_pkg.sv
// Types shared by the message object handler
package can_msg_pkg;
  typedef enum logic {RX_IDLE = 1'b0, RX_MATCH = 1'b1} rx_state_e;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_e;
endpackage

// File: msg_fifo.sv
// Received frame FIFO with valid and ready on both sides
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i, // Clock
  input wire logic srst_i, // Sync reset
  input wire logic in_valid_i, // Write offer
  output logic in_ready_o, // Not full
  input wire logic [WIDTH-1:0] in_data_i, // Write word
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i, // Reader takes
  output logic [WIDTH-1:0] out_data_o // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire do_wr = in_valid_i & in_ready_o;
  wire do_rd = out_valid_o & out_ready_i;
  // Full when pointers differ only in the wrap bit
  assign in_ready_o = ~((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  // Storage
  always_ff @(posedge ref_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  // Pointers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(do_wr);
      rd_ptr <= rd_ptr + (AW+1)'(do_rd);
    end
  end
endmodule

// File: lowest_pick.sv
// Picks the lowest set bit of a request vector
`timescale 1ns/1ps
module lowest_pick #(
  parameter int N = 32
) (
  input wire logic [N-1:0] req_i, // Request bits
  output logic found_o, // Any bit set
  output logic [$clog2(N)-1:0] idx_o // Lowest set index
);
  // Scan from the top so the lowest index wins
  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o = ($clog2(N))'(i);
      end
    end
  end
endmodule

// File: can_message_object_handler.sv
// Message object store, acceptance filter and transmit scheduler
//
// Contract
// - Extended mask set makes IDE count
// - Standard ids use bits 28..18 only
// - Transmit object sends data, answers remotes
// - Receive object sends remote, stores data
// - Direction mask set makes direction count
// - End-of-buffer zero chains objects into FIFO
// - New data flag sticky until software clears
// - Receive object overwrite with new data sets lost flag
// - Reception sets pending when receive enable
// - Transmission sets pending when transmit enable
// - Identifier reports lowest pending object number
// - Remote frame sets request when answering enabled
// - Request flag shows waiting transmission
// - Length codes above eight mean eight
// - Stored data frame overwrites length code
// - First bus byte lands in byte zero
// - All eight byte slots written on store
// - Several matches store into lowest number
// - Mask bit one compares, zero ignores
// - Masks apply only with mask use set
// - Invalid objects ignored by filter and transmit scheduler; CPU writes still set their flags
`timescale 1ns/1ps
`include "can_msg_cfg.svh"
module can_message_object_handler import can_msg_pkg::*; #(
  parameter int NOBJ = `MO_COUNT,
  parameter int FIFO_DEPTH = `MO_FIFO_DEPTH
) (
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic srst_i, // Sync reset
  input wire logic cfg_wr_i, // Write one object
  input wire logic [4:0] cfg_obj_i, // Object index
  input wire logic cfg_object_valid_i, // Object valid
  input wire logic cfg_filter_mask_use_i, // Use masks
  input wire logic [28:0] cfg_object_identifier_i, // Identifier
  input wire logic [28:0] cfg_id_compare_mask_i, // Identifier mask
  input wire logic cfg_long_id_i, // 29-bit identifier
  input wire logic cfg_long_id_mask_en_i, // IDE mask
  input wire logic cfg_dir_tx_i, // Direction transmit
  input wire logic cfg_way_mask_en_i, // Direction mask
  input wire logic cfg_end_of_buffer_i, // Last in chain
  input wire logic cfg_receive_irq_enable_i, // Rx irq enable
  input wire logic cfg_transmit_irq_enable_i, // Tx irq enable
  input wire logic cfg_remote_answer_enable_i, // Remote answer
  input wire logic [3:0] cfg_byte_count_code_i, // Length code
  input wire logic [63:0] cfg_data_i, // Data bytes
  input wire logic cfg_data_new_i, // Data written by CPU
  input wire logic cfg_transmit_request_i, // Set request
  input wire logic [4:0] clr_obj_i, // Clear target
  input wire logic clr_new_data_i, // Clear new data
  input wire logic clr_msg_lost_i, // Clear lost
  input wire logic clr_irq_pending_i, // Clear pending
  input wire logic clr_transmit_request_i, // Cancel request
  input wire logic rx_valid_i, // Frame from core
  output logic rx_ready_o, // FIFO has room
  input wire logic [28:0] rx_id_i, // Frame identifier
  input wire logic rx_ide_i, // Extended frame
  input wire logic rx_rtr_i, // Remote frame
  input wire logic [3:0] rx_dlc_i, // Length code
  input wire logic [63:0] rx_data_i, // Byte 0 in [7:0]
  output logic tx_valid_o, // Frame offered
  output logic [4:0] tx_obj_o, // Object index
  output logic [28:0] tx_id_o, // Identifier
  output logic tx_ide_o, // Extended frame
  output logic tx_rtr_o, // Remote frame
  output logic [3:0] tx_dlc_o, // Length code
  output logic [3:0] tx_len_o, // Byte count
  output logic [63:0] tx_data_o, // Data bytes
  input wire logic tx_done_i, // Sent successfully
  input wire logic tx_fail_i, // Lost or error
  input wire logic status_irq_i, // Status interrupt
  output logic [15:0] irq_id_o, // Interrupt identifier
  output logic [NOBJ-1:0] new_data_o, // New data flags
  output logic [NOBJ-1:0] msg_lost_o, // Lost flags
  output logic [NOBJ-1:0] irq_pending_o, // Pending flags
  output logic [NOBJ-1:0] transmit_request_o, // Request flags
  input wire logic [4:0] rd_obj_i, // Read index
  output logic [28:0] rd_id_o, // Read identifier
  output logic [3:0] rd_dlc_o, // Read length code
  output logic [63:0] rd_data_o // Read data
);
  localparam int FW = 29 + 1 + 1 + 4 + 64;
  localparam int IW = $clog2(NOBJ);

  // ------------------------------------------------------------
  // Object storage
  // ------------------------------------------------------------
  logic [28:0] obj_id [NOBJ];
  logic [28:0] obj_mask [NOBJ];
  logic [3:0] obj_dlc [NOBJ];
  logic [63:0] obj_data [NOBJ];
  logic [NOBJ-1:0] obj_valid, obj_filter_mask_use, obj_xtd, obj_long_id_mask_en, obj_dir, obj_way_mask_en;
  logic [NOBJ-1:0] obj_eob, obj_receive_irq_enable, obj_transmit_irq_enable, obj_remote_answer_enable;
  logic [NOBJ-1:0] new_data, msg_lost, irq_pnd, txreq;
  rx_state_e rx_state;
  tx_state_e tx_state;

  // ------------------------------------------------------------
  // Receive FIFO and frame latch
  // ------------------------------------------------------------
  logic [FW-1:0] fifo_out;
  logic fifo_valid;
  logic [28:0] f_id;
  logic f_ide, f_rtr;
  logic [3:0] f_dlc;
  logic [63:0] f_data;
  wire fifo_take = fifo_valid & (rx_state == RX_IDLE);

  msg_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i({rx_id_i, rx_ide_i, rx_rtr_i, rx_dlc_i, rx_data_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take),
    .out_data_o(fifo_out)
  );

  // Latch one frame, wait out CPU writes, then commit
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_state <= RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (fifo_take) begin
            rx_state <= RX_MATCH;
          end
        end
        RX_MATCH: begin
          if (!cfg_wr_i) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Frame latch; bus byte order kept as delivered
  always_ff @(posedge ref_clk_i) begin
    if (fifo_take) begin
      {f_id, f_ide, f_rtr, f_dlc, f_data} <= fifo_out;
    end
  end

  // ------------------------------------------------------------
  // Acceptance filter, one lane per object
  // ------------------------------------------------------------
  logic [NOBJ-1:0] match, cand;
  logic rx_hit;
  logic [IW-1:0] win;
  for (genvar k = 0; k < NOBJ; k++) begin : g_filter
    wire [28:0] use_mask = obj_filter_mask_use[k] ? obj_mask[k] : `MO_ALL_ID_MASK;
    wire [28:0] eff_mask = obj_xtd[k] ? use_mask : (use_mask & `MO_STD_ID_MASK);
    wire id_ok = ((f_id ^ obj_id[k]) & eff_mask) == 29'h00000000;
    wire ide_ok = (obj_filter_mask_use[k] & ~obj_long_id_mask_en[k]) | (f_ide == obj_xtd[k]);
    wire dir_ok = (obj_filter_mask_use[k] & ~obj_way_mask_en[k]) | (f_rtr == obj_dir[k]);
    assign match[k] = obj_valid[k] & id_ok & ide_ok & dir_ok;
    // Chain members that still hold unread data pass the frame on
    assign cand[k] = match[k] & (~new_data[k] | obj_eob[k]);
  end

  lowest_pick #(.N(NOBJ)) rx_pick (
    .req_i(cand),
    .found_o(rx_hit),
    .idx_o(win)
  );

  // Commit strobes for the winning object
  wire rx_commit = (rx_state == RX_MATCH) & !cfg_wr_i & rx_hit;
  wire rx_store = rx_commit & !f_rtr;
  wire rx_remote = rx_commit & f_rtr;
  wire [NOBJ-1:0] win_sel = NOBJ'(1) << win;
  wire [NOBJ-1:0] cfg_sel = NOBJ'(1) << cfg_obj_i;
  wire [NOBJ-1:0] clr_sel = NOBJ'(1) << clr_obj_i;

  // ------------------------------------------------------------
  // Transmit scheduler
  // ------------------------------------------------------------
  logic tx_hit;
  logic [IW-1:0] tx_pick_idx;
  logic [IW-1:0] tx_cur;
  wire [NOBJ-1:0] tx_cand = txreq & obj_valid;
  wire tx_ok = (tx_state == TX_SEND) & tx_done_i;
  wire [NOBJ-1:0] tx_sel = NOBJ'(1) << tx_cur;
  wire [3:0] pick_dlc = obj_dlc[tx_pick_idx];

  lowest_pick #(.N(NOBJ)) tx_pick (
    .req_i(tx_cand),
    .found_o(tx_hit),
    .idx_o(tx_pick_idx)
  );

  // Offer the lowest requesting object until done or failed
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tx_state <= TX_IDLE;
      tx_cur <= '0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_hit) begin
            tx_state <= TX_SEND;
            tx_cur <= tx_pick_idx;
          end
        end
        TX_SEND: begin
          if (tx_done_i || tx_fail_i) begin
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Frame fields captured at launch
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      {tx_id_o, tx_ide_o, tx_rtr_o, tx_dlc_o, tx_len_o, tx_data_o} <= '0;
    end else if (tx_state == TX_IDLE && tx_hit) begin
      tx_id_o <= obj_id[tx_pick_idx];
      tx_ide_o <= obj_xtd[tx_pick_idx];
      tx_rtr_o <= ~obj_dir[tx_pick_idx];
      tx_dlc_o <= pick_dlc;
      tx_len_o <= (pick_dlc > `MO_MAX_BYTES) ? `MO_MAX_BYTES : pick_dlc;
      tx_data_o <= obj_data[tx_pick_idx];
    end
  end
  assign tx_valid_o = (tx_state == TX_SEND);
  assign tx_obj_o = 5'(tx_cur);

  // ------------------------------------------------------------
  // Per-object configuration, data and flags
  // ------------------------------------------------------------
  for (genvar k = 0; k < NOBJ; k++) begin : g_obj
    wire w_cfg = cfg_wr_i & cfg_sel[k];
    wire w_rx = rx_store & win_sel[k];
    wire done_k = tx_ok & tx_sel[k];
    wire set_nd = w_rx | (w_cfg & cfg_data_new_i);
    wire set_ml = w_rx & ~obj_dir[k] & new_data[k];
    wire set_ip = (rx_commit & win_sel[k] & obj_receive_irq_enable[k]) | (done_k & obj_transmit_irq_enable[k]);
    wire set_tr = (rx_remote & win_sel[k] & obj_remote_answer_enable[k]) | (w_cfg & cfg_transmit_request_i);
    wire clr_tr = (clr_transmit_request_i & clr_sel[k]) | done_k;
    // Configuration written by the CPU
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        {obj_valid[k], obj_filter_mask_use[k], obj_xtd[k], obj_long_id_mask_en[k], obj_dir[k]} <= 5'h00;
        {obj_way_mask_en[k], obj_eob[k], obj_receive_irq_enable[k], obj_transmit_irq_enable[k], obj_remote_answer_enable[k]} <= 5'h00;
        obj_mask[k] <= '0;
      end else if (w_cfg) begin
        {obj_valid[k], obj_filter_mask_use[k], obj_xtd[k], obj_long_id_mask_en[k], obj_dir[k]} <= {cfg_object_valid_i,
          cfg_filter_mask_use_i, cfg_long_id_i, cfg_long_id_mask_en_i, cfg_dir_tx_i};
        {obj_way_mask_en[k], obj_eob[k], obj_receive_irq_enable[k], obj_transmit_irq_enable[k], obj_remote_answer_enable[k]} <= {cfg_way_mask_en_i,
          cfg_end_of_buffer_i, cfg_receive_irq_enable_i, cfg_transmit_irq_enable_i, cfg_remote_answer_enable_i};
        obj_mask[k] <= cfg_id_compare_mask_i;
      end
    end
    // Identifier, length and data; reception writes all eight slots
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        obj_id[k] <= '0;
        obj_dlc[k] <= '0;
        obj_data[k] <= '0;
      end else if (w_cfg) begin
        obj_id[k] <= cfg_object_identifier_i;
        obj_dlc[k] <= cfg_byte_count_code_i;
        obj_data[k] <= cfg_data_i;
      end else if (w_rx) begin
        obj_id[k] <= obj_xtd[k] ? f_id : {f_id[28:18], obj_id[k][17:0]};
        obj_dlc[k] <= f_dlc;
        obj_data[k] <= f_data;
      end
    end
    // Sticky flags; a hardware set beats a same-cycle clear
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        {new_data[k], msg_lost[k], irq_pnd[k], txreq[k]} <= 4'h0;
      end else begin
        new_data[k] <= set_nd | (new_data[k] & ~(clr_new_data_i & clr_sel[k]));
        msg_lost[k] <= set_ml | (msg_lost[k] & ~(clr_msg_lost_i & clr_sel[k]));
        irq_pnd[k] <= set_ip | (irq_pnd[k] & ~(clr_irq_pending_i & clr_sel[k]));
        txreq[k] <= set_tr | (txreq[k] & ~clr_tr);
      end
    end
  end

  assign new_data_o = new_data;
  assign msg_lost_o = msg_lost;
  assign irq_pending_o = irq_pnd;
  assign transmit_request_o = txreq;

  // ------------------------------------------------------------
  // Interrupt identifier and read port
  // ------------------------------------------------------------
  logic irq_hit;
  logic [IW-1:0] irq_idx;
  lowest_pick #(.N(NOBJ)) irq_pick (
    .req_i(irq_pnd),
    .found_o(irq_hit),
    .idx_o(irq_idx)
  );
  wire [15:0] irq_num = 16'(irq_idx) + 16'h0001;
  wire [15:0] next_irq_id = status_irq_i ? `MO_IRQ_STATUS : (irq_hit ? irq_num : `MO_IRQ_NONE);

  // Registered status outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_id_o <= `MO_IRQ_NONE;
      rd_id_o <= '0;
      rd_dlc_o <= '0;
      rd_data_o <= '0;
    end else begin
      irq_id_o <= next_irq_id;
      rd_id_o <= obj_id[rd_obj_i];
      rd_dlc_o <= obj_dlc[rd_obj_i];
      rd_data_o <= obj_data[rd_obj_i];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  wire [NOBJ-1:0] below_win = win_sel - NOBJ'(1);

  lowest_win_a: assert property (rx_commit |-> (cand & below_win) == '0)
    else $error("frame stored above a lower match");
  ide_filter_a: assert property (rx_commit |->
    (f_ide == obj_xtd[win]) || (obj_filter_mask_use[win] && !obj_long_id_mask_en[win]))
    else $error("IDE filter violated");
  dir_filter_a: assert property (rx_commit |->
    (f_rtr == obj_dir[win]) || (obj_filter_mask_use[win] && !obj_way_mask_en[win]))
    else $error("direction filter violated");
  nomask_id_a: assert property (rx_commit && !obj_filter_mask_use[win] |->
    ((f_id ^ obj_id[win]) & (obj_xtd[win] ? `MO_ALL_ID_MASK : `MO_STD_ID_MASK)) == '0)
    else $error("unmasked identifier mismatch stored");
  valid_only_a: assert property (rx_commit |-> obj_valid[win])
    else $error("invalid object accepted a frame");
  new_data_a: assert property (rx_store |=> new_data[$past(win)])
    else $error("new data flag not set on store");
  lost_flag_a: assert property (rx_store && new_data[win] && !obj_dir[win] |=> msg_lost[$past(win)])
    else $error("message lost flag not set");
  rx_pending_a: assert property (rx_commit && obj_receive_irq_enable[win] |=> irq_pnd[$past(win)])
    else $error("receive pending not set");
  dlc_store_a: assert property (rx_store && !cfg_wr_i |=> obj_dlc[$past(win)] == $past(f_dlc))
    else $error("length code not overwritten");
  remote_ans_a: assert property (rx_remote && obj_remote_answer_enable[win] |=> txreq[$past(win)])
    else $error("remote frame not answered");
  tx_clear_a: assert property (tx_ok && !(cfg_wr_i && cfg_transmit_request_i && cfg_obj_i == tx_obj_o) |=>
    !txreq[$past(tx_cur)] ##1 (tx_state == TX_IDLE) || tx_valid_o)
    else $error("request not cleared after send");
  tx_pending_a: assert property (tx_ok && obj_transmit_irq_enable[tx_cur] |=> irq_pnd[$past(tx_cur)])
    else $error("transmit pending not set");
  tx_len_a: assert property (tx_valid_o |-> tx_len_o == ((tx_dlc_o > 4'h8) ? 4'h8 : tx_dlc_o))
    else $error("byte count wrong for length code");
  irq_id_a: assert property (!status_irq_i && irq_pnd[0] |=> irq_id_o == 16'h0001)
    else $error("identifier misses object one");

  rx_store_c: cover property (rx_store ##[1:20] rx_store);
  remote_c: cover property (rx_remote && obj_remote_answer_enable[win] ##[1:10] tx_valid_o);
  tx_done_c: cover property (tx_valid_o ##[1:50] tx_done_i);
  fifo_full_c: cover property (!rx_ready_o);
endmodule

// File: can_node_model.sv
// Far-side bus nodes model
`timescale 1ns/1ps
module can_node_model (
  input wire logic ref_clk_i, // Clock
  input wire logic rx_ready_i, // Handler FIFO room
  output logic rx_valid_o, // Frame offered
  output logic [28:0] rx_id_o, // Identifier
  output logic rx_ide_o, // Extended frame
  output logic rx_rtr_o, // Remote frame
  output logic [3:0] rx_dlc_o, // Length code
  output logic [63:0] rx_data_o, // Byte 0 first on bus
  input wire logic tx_valid_i, // Handler offers a frame
  output logic tx_done_o, // Sent pulse
  output logic tx_fail_o // Lost pulse
);
  int delay = 12;
  logic fail_next = 1'h0;
  // ----
  // Frame source
  // ----
  // Offer one frame until taken
  task automatic send(input logic [28:0] id, input logic ide, input logic rtr, input logic [3:0] dlc,
      input logic [63:0] d);
    @(negedge ref_clk_i);
    {rx_valid_o, rx_id_o, rx_ide_o, rx_rtr_o, rx_dlc_o, rx_data_o} = {1'h1, id, ide, rtr, dlc, d};
    while (rx_ready_i !== 1'h1) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
  endtask
  // Released lines show the inverse of the last frame
  task automatic idle;
    @(negedge ref_clk_i);
    rx_valid_o = 1'h0;
    {rx_id_o, rx_ide_o, rx_rtr_o, rx_dlc_o, rx_data_o} = ~{rx_id_o, rx_ide_o, rx_rtr_o, rx_dlc_o, rx_data_o};
  endtask
  // ----
  // Transmit answer
  // ----
  // Answer each offer after a delay
  initial begin
    {rx_valid_o, rx_id_o, rx_ide_o, rx_rtr_o, rx_dlc_o, rx_data_o, tx_done_o, tx_fail_o} = '0;
    forever begin
      @(negedge ref_clk_i);
      if (tx_valid_i === 1'h1) begin
        repeat (delay) @(negedge ref_clk_i);
        tx_fail_o = fail_next;
        tx_done_o = !fail_next;
        fail_next = 1'h0;
        @(negedge ref_clk_i);
        tx_done_o = 1'h0;
        tx_fail_o = 1'h0;
      end
    end
  end
endmodule

// File: can_message_object_handler_tb.sv
// Bench for the message object handler
`timescale 1ns/1ps
module can_message_object_handler_tb;
  localparam logic [11:0] fv = 12'h800, fu = 12'h400, fx = 12'h200, fmx = 12'h100, fd = 12'h080, fmd = 12'h040;
  localparam logic [11:0] fe = 12'h020, fri = 12'h010, fti = 12'h008, frm = 12'h004, fnd = 12'h002, ftr = 12'h001;
  localparam logic [63:0] pat = 64'h8877665544332211;
  localparam logic [28:0] ext = 29'h0ABCDE00, ext5 = 29'h0ABCDE55, msk = 29'h1FFFFF00;
  logic ref_clk_i, srst_i, cfg_wr_i, cfg_object_valid_i, cfg_filter_mask_use_i, cfg_long_id_i;
  logic cfg_long_id_mask_en_i, cfg_dir_tx_i, cfg_way_mask_en_i, cfg_end_of_buffer_i, cfg_receive_irq_enable_i;
  logic cfg_transmit_irq_enable_i, cfg_remote_answer_enable_i, cfg_data_new_i, cfg_transmit_request_i;
  logic clr_new_data_i, clr_msg_lost_i, clr_irq_pending_i, clr_transmit_request_i, rx_valid_i, rx_ready_o;
  logic rx_ide_i, rx_rtr_i, tx_valid_o, tx_ide_o, tx_rtr_o, tx_done_i, tx_fail_i, status_irq_i;
  logic [4:0] cfg_obj_i, clr_obj_i, tx_obj_o, rd_obj_i;
  logic [28:0] cfg_object_identifier_i, cfg_id_compare_mask_i, rx_id_i, tx_id_o, rd_id_o;
  logic [3:0] cfg_byte_count_code_i, rx_dlc_i, tx_dlc_o, tx_len_o, rd_dlc_o;
  logic [63:0] cfg_data_i, rx_data_i, tx_data_o, rd_data_o;
  logic [15:0] irq_id_o;
  logic [31:0] new_data_o, msg_lost_o, irq_pending_o, transmit_request_o;
  int n_mismatch = 0, checks_done = 0;
  can_message_object_handler dut (.ref_clk_i, .srst_i, .cfg_wr_i, .cfg_obj_i, .cfg_object_valid_i,
    .cfg_filter_mask_use_i, .cfg_object_identifier_i, .cfg_id_compare_mask_i, .cfg_long_id_i, .cfg_long_id_mask_en_i,
    .cfg_dir_tx_i, .cfg_way_mask_en_i, .cfg_end_of_buffer_i, .cfg_receive_irq_enable_i, .cfg_transmit_irq_enable_i,
    .cfg_remote_answer_enable_i, .cfg_byte_count_code_i, .cfg_data_i, .cfg_data_new_i, .cfg_transmit_request_i,
    .clr_obj_i, .clr_new_data_i, .clr_msg_lost_i, .clr_irq_pending_i, .clr_transmit_request_i, .rx_valid_i,
    .rx_ready_o, .rx_id_i, .rx_ide_i, .rx_rtr_i, .rx_dlc_i, .rx_data_i, .tx_valid_o, .tx_obj_o, .tx_id_o, .tx_ide_o,
    .tx_rtr_o, .tx_dlc_o, .tx_len_o, .tx_data_o, .tx_done_i, .tx_fail_i, .status_irq_i, .irq_id_o, .new_data_o,
    .msg_lost_o, .irq_pending_o, .transmit_request_o, .rd_obj_i, .rd_id_o, .rd_dlc_o, .rd_data_o);
  can_node_model m (.ref_clk_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i),
    .rx_ide_o(rx_ide_i), .rx_rtr_o(rx_rtr_i), .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o),
    .tx_done_o(tx_done_i), .tx_fail_o(tx_fail_i));
  // ----
  // Checks and drivers
  // ----
  function automatic logic [28:0] sid(input logic [10:0] x);
    return {x, 18'h00000};
  endfunction
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Write one object, flags packed valid..request
  task automatic cfg(input logic [4:0] o, input logic [28:0] id, input logic [28:0] mk, input logic [11:0] f,
      input logic [3:0] c = 4'h8);
    @(negedge ref_clk_i);
    {cfg_object_valid_i, cfg_filter_mask_use_i, cfg_long_id_i, cfg_long_id_mask_en_i, cfg_dir_tx_i, cfg_way_mask_en_i,
      cfg_end_of_buffer_i, cfg_receive_irq_enable_i, cfg_transmit_irq_enable_i, cfg_remote_answer_enable_i,
      cfg_data_new_i, cfg_transmit_request_i} = f;
    {cfg_obj_i, cfg_object_identifier_i, cfg_id_compare_mask_i, cfg_byte_count_code_i, cfg_data_i} = {o, id, mk, c, pat};
    cfg_wr_i = 1'h1;
    @(negedge ref_clk_i);
    cfg_wr_i = 1'h0;
  endtask
  // Clear flags of one object
  task automatic clr(input logic [4:0] o, input logic [3:0] w);
    @(negedge ref_clk_i);
    clr_obj_i = o;
    {clr_new_data_i, clr_msg_lost_i, clr_irq_pending_i, clr_transmit_request_i} = w;
    @(negedge ref_clk_i);
    {clr_new_data_i, clr_msg_lost_i, clr_irq_pending_i, clr_transmit_request_i} = 4'h0;
    @(negedge ref_clk_i);
  endtask
  task automatic rx(input logic [28:0] id, input logic ide = 1'h0, input logic rtr = 1'h0, input logic [3:0] c = 4'h8);
    m.send(id, ide, rtr, c, pat);
    m.idle();
    repeat (5) @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [4:0] o);
    @(negedge ref_clk_i);
    rd_obj_i = o;
    @(negedge ref_clk_i);
  endtask
  task automatic wait_tx(input logic v);
    for (int i = 0; i < 60 && tx_valid_o !== v; i++) @(negedge ref_clk_i);
    chk("offer", tx_valid_o, v);
  endtask
  task automatic hit(input logic [4:0] o, input logic e);
    chk("new", new_data_o[o], e);
    clr(o, 4'hF);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_store;
    cfg(0, sid(11'h123), 29'h0, fv | fe | fri);
    rx(sid(11'h124));
    chk("std", new_data_o[0], 1'h0);
    rx(sid(11'h123) | 29'h00015, 1'h0, 1'h0, 4'h4);
    chk("new", new_data_o[0], 1'h1);
    chk("pend", irq_pending_o[0], 1'h1);
    chk("irq", irq_id_o, 16'h0001);
    chk("lost", msg_lost_o[0], 1'h0);
    rd(0);
    chk("id", rd_id_o, sid(11'h123));
    chk("dlc", rd_dlc_o, 4'h4);
    chk("data", rd_data_o, pat);
    rx(sid(11'h123), 1'h0, 1'h0, 4'hB);
    chk("lost", msg_lost_o[0], 1'h1);
    status_irq_i = 1'h1;
    @(negedge ref_clk_i);
    chk("irq", irq_id_o, 16'h8000);
    status_irq_i = 1'h0;
    clr(0, 4'hF);
    chk("new", new_data_o[0], 1'h0);
    chk("irq", irq_id_o, 16'h0000);
  endtask
  task automatic t_filter;
    cfg(1, ext, msk, fv | fu | fx | fe);
    rx(ext5, 1'h1);
    hit(1, 1'h1);
    rx(ext5);
    hit(1, 1'h1);
    cfg(1, ext, msk, fv | fu | fx | fmx | fe);
    rx(ext5);
    hit(1, 1'h0);
    cfg(1, ext, msk, fv | fx | fe);
    rx(ext5, 1'h1);
    hit(1, 1'h0);
    cfg(2, 29'h00000777, 29'h0, fv | fx | fe);
    cfg(3, 29'h00000777, 29'h0, fv | fx | fe);
    rx(29'h00000777, 1'h1);
    hit(2, 1'h1);
    hit(3, 1'h0);
    cfg(2, 29'h00000777, 29'h0, fx | fe | ftr);
    rx(29'h00000777, 1'h1);
    chk("offer", tx_valid_o, 1'h0);
    chk("rq", transmit_request_o[2], 1'h1);
    hit(2, 1'h0);
    hit(3, 1'h1);
    chk("rq", transmit_request_o[2], 1'h0);
    cfg(4, sid(11'h555), 29'h1FFFFFFF, fv | fu | fe | fri);
    rx(sid(11'h555), 1'h0, 1'h1);
    chk("dir", irq_pending_o[4], 1'h1);
    clr(4, 4'hF);
    cfg(4, sid(11'h555), 29'h1FFFFFFF, fv | fu | fmd | fe | fri);
    rx(sid(11'h555), 1'h0, 1'h1);
    chk("dir", irq_pending_o[4], 1'h0);
  endtask
  task automatic t_chain;
    cfg(5, sid(11'h0A5), 29'h0, fv);
    cfg(6, sid(11'h0A5), 29'h0, fv | fe);
    rx(sid(11'h0A5));
    rx(sid(11'h0A5));
    chk("chain", new_data_o[6:5], 2'h3);
    chk("lost", msg_lost_o[5], 1'h0);
    cfg(11, 29'h0, 29'h0, fe | fnd);
    chk("cpu", new_data_o[11], 1'h1);
  endtask
  task automatic t_tx;
    m.delay = 1;
    cfg(7, sid(11'h2F0), 29'h0, fv | fd | fe | fti | ftr, 4'hC);
    wait_tx(1'h1);
    chk("obj", tx_obj_o, 5'h07);
    chk("rtr", tx_rtr_o, 1'h0);
    chk("len", tx_len_o, 4'h8);
    chk("dlc", tx_dlc_o, 4'hC);
    chk("ide", tx_ide_o, 1'h0);
    chk("data", tx_data_o, pat);
    chk("rq", transmit_request_o[7], 1'h1);
    wait_tx(1'h0);
    chk("rq", transmit_request_o[7], 1'h0);
    chk("pend", irq_pending_o[7], 1'h1);
    clr(7, 4'hF);
    m.delay = 12;
    m.fail_next = 1'h1;
    cfg(7, sid(11'h2F0), 29'h0, fv | fd | fe | ftr, 4'hC);
    wait_tx(1'h1);
    wait_tx(1'h0);
    chk("rq", transmit_request_o[7], 1'h1);
    wait_tx(1'h1);
    wait_tx(1'h0);
    chk("rq", transmit_request_o[7], 1'h0);
    chk("pend", irq_pending_o[7], 1'h0);
    cfg(8, sid(11'h3C3), 29'h0, fv | fe | ftr);
    wait_tx(1'h1);
    chk("rtr", tx_rtr_o, 1'h1);
    chk("id", tx_id_o, sid(11'h3C3));
    wait_tx(1'h0);
    cfg(9, sid(11'h1E1), 29'h0, fv | fd | fe | frm);
    cfg(10, sid(11'h1E2), 29'h0, fv | fd | fe);
    rx(sid(11'h1E2), 1'h0, 1'h1);
    chk("rq", transmit_request_o[10], 1'h0);
    rx(sid(11'h1E1), 1'h0, 1'h1);
    wait_tx(1'h1);
    chk("obj", tx_obj_o, 5'h09);
    chk("rtr", tx_rtr_o, 1'h0);
    wait_tx(1'h0);
  endtask
  // Stall handler so the FIFO fills, then drain
  task automatic t_fifo;
    @(negedge ref_clk_i);
    {cfg_obj_i, cfg_object_valid_i, cfg_wr_i} = {5'h1F, 1'h0, 1'h1};
    repeat (17) m.send(sid(11'h123), 1'h0, 1'h0, 4'h8, pat);
    m.idle();
    chk("full", rx_ready_o, 1'h0);
    cfg_wr_i = 1'h0;
    repeat (50) @(negedge ref_clk_i);
    chk("drained", rx_ready_o, 1'h1);
    chk("lost", msg_lost_o[0], 1'h1);
  endtask
  // ----
  // Run
  // ----
  initial begin
    ref_clk_i = 1'h0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {cfg_wr_i, clr_obj_i, clr_new_data_i, clr_msg_lost_i, clr_irq_pending_i, clr_transmit_request_i, status_irq_i,
      rd_obj_i} = '0;
    srst_i = 1'h1;
    repeat (12) @(negedge ref_clk_i);
    srst_i = 1'h0;
    chk("ready", rx_ready_o, 1'h1);
    chk("irq", irq_id_o, 16'h0000);
    t_store;
    t_filter;
    t_chain;
    t_tx;
    t_fifo;
    report_and_stop;
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    n_mismatch++;
    report_and_stop;
  end
endmodule
